// file: wdsl_cfg.svh
// Register map, field positions, reset values and timing counts of the watchdog control
`ifndef WDSL_CFG_SVH
`define WDSL_CFG_SVH

`define WDSL_OFS_ENABLE      12'h000
`define WDSL_OFS_CONFIG      12'h008
`define WDSL_OFS_CMD         12'h00C
`define WDSL_OFS_STATUS      12'h014
`define WDSL_OFS_FLAGS       12'h018
`define WDSL_OFS_IEN         12'h01C
`define WDSL_OFS_KEY         12'h020
`define WDSL_OFS_SYNC        12'h024

`define WDSL_CFG_CLR_SEL     0
`define WDSL_CFG_RSTSUP      8
`define WDSL_CFG_PER_LO      16
`define WDSL_CFG_PER_HI      19
`define WDSL_CFG_WARN_LO     24
`define WDSL_CFG_WARN_HI     25
`define WDSL_CFG_WINDOW_LO   28
`define WDSL_CFG_WINDOW_HI   30
`define WDSL_STATUS_LOCK     31
`define WDSL_NUM_SRC         5

`define WDSL_KEY_UNLOCK      16'hABE8
`define WDSL_PER_RESET       4'hF
`define WDSL_CONFIG_RESET    32'h000F_0000

`define WDSL_CLR_MARGIN_CYC  4
`define WDSL_SYNC_CYC        (`WDSL_CLR_MARGIN_CYC - 1)

`endif

// file: wdsl_pkg.sv
// Types shared by the watchdog control files
package wdsl_pkg;
   typedef logic [18:0] wdsl_cnt_t;
   typedef logic [3:0]  wdsl_per_t;
   typedef enum logic [0:0] {SYNC_IDLE, SYNC_XFER} wdsl_sync_e;
endpackage

// file: wdsl_sync2.sv
// Two-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ns
module wdsl_sync2 #(
   parameter int WIDTH = 2
)(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Levels
   input  wire logic [WIDTH-1:0] d_async,
   output logic      [WIDTH-1:0] q_sync
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic meta_r;
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               meta_r    <= 1'b0;
               q_sync[i] <= 1'b0;
            end
            else
            begin
               meta_r    <= d_async[i];
               q_sync[i] <= meta_r;
            end
         end
      end
   endgenerate
endmodule

// file: wdsl_counter.sv
// Watchdog counter with period, warning and window compare
`timescale 1ns/1ns
module wdsl_counter #(
   parameter int PERIOD_SHIFT = 0
)(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // Control
   input  wire logic                run,
   input  wire logic                clr,
   input  wire wdsl_pkg::wdsl_per_t period_sel,
   input  wire logic [1:0]          warnsel,
   input  wire logic [2:0]          winsel,
   // Events
   output logic                     expiry_p,
   output logic                     warn_p,
   output logic                     early
);
   import wdsl_pkg::*;

   wdsl_cnt_t cnt_r;
   wdsl_cnt_t period;
   wdsl_cnt_t warn_lim;
   wdsl_cnt_t win_lim;
   int        expo;

   // Codes 0..6 give 2^n+1, codes 7..15 plain powers of two
   always_comb
   begin
      expo = int'(period_sel) + 3 - PERIOD_SHIFT;
      if (expo < 3)
         expo = 3;
      period = wdsl_cnt_t'(19'h00001 << expo);
      if (period_sel < 4'h7)
         period = period + 19'h00001;
      warn_lim = wdsl_cnt_t'((period >> 2) * warnsel);
      win_lim  = wdsl_cnt_t'((period >> 3) * winsel);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_r <= '0;
      else if (clr || (run && cnt_r == period - 19'h00001))
         cnt_r <= '0;
      else if (run)
         cnt_r <= cnt_r + 19'h00001;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         expiry_p <= 1'b0;
         warn_p <= 1'b0;
      end
      else
      begin
         expiry_p <= run && !clr && cnt_r == period - 19'h00001;
         warn_p <= run && !clr && warnsel != 2'h0 && cnt_r == warn_lim;
      end
   end

   assign early = (winsel != 3'h0) && (cnt_r < win_lim);
endmodule

// file: wdsl_top.sv
// Watchdog service, lock and register control behind an APB slave
`timescale 1ns/1ns
`include "wdsl_cfg.svh"
module wdsl_top #(
   parameter int PERIOD_SHIFT = 0
)(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Event inputs from the routing system
   input  wire logic        EVT0_IN,
   input  wire logic        EVT1_IN,
   // Watchdog outputs
   output logic             IRQ,
   output logic             WDOG_RST,
   output logic             LOCKED
);
   import wdsl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait state, write lands when PREADY is seen high
   logic                     acc;
   logic                     wr_fire;
   logic [31:0]              rd_data;
   logic                     mapped;
   logic                     enable_r;
   logic [31:0]              config_r;
   logic                     lock_r;
   logic [`WDSL_NUM_SRC-1:0] flags_r;
   logic [`WDSL_NUM_SRC-1:0] ien_r;
   logic                     busy_r;
   wdsl_sync_e               sync_st_r;
   logic [1:0]               sync_cnt_r;
   logic                     sw_clr_p;
   logic [1:0]               evt_s;
   logic [1:0]               evt_d_r;
   logic [1:0]               evt_rise;
   logic [1:0]               seen_r;
   logic                     clr;
   logic                     expiry_p;
   logic                     warn_p;
   logic                     early;
   logic [`WDSL_NUM_SRC-1:0] ev_set;

   assign acc     = PSEL && PENABLE;
   assign wr_fire = acc && PREADY && PWRITE;

   always_comb
   begin
      rd_data = 32'h0000_0000;
      mapped  = 1'b1;
      if (PADDR == `WDSL_OFS_ENABLE)
         rd_data = {31'h0000_0000, enable_r};
      else if (PADDR == `WDSL_OFS_CONFIG)
         rd_data = config_r;
      else if (PADDR == `WDSL_OFS_CMD || PADDR == `WDSL_OFS_KEY)
         rd_data = 32'h0000_0000;
      else if (PADDR == `WDSL_OFS_STATUS)
         rd_data[`WDSL_STATUS_LOCK] = lock_r;
      else if (PADDR == `WDSL_OFS_FLAGS)
         rd_data = {27'h000_0000, flags_r};
      else if (PADDR == `WDSL_OFS_IEN)
         rd_data = {27'h000_0000, ien_r};
      else if (PADDR == `WDSL_OFS_SYNC)
         rd_data = {31'h0000_0000, busy_r};
      else
         mapped = 1'b0;
   end

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY  <= acc && !PREADY;
         PRDATA  <= (acc && !PREADY && !PWRITE) ? rd_data : 32'h0000_0000;
         PSLVERR <= acc && !PREADY && !mapped;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Lockable registers
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         enable_r <= 1'b0;
         config_r <= `WDSL_CONFIG_RESET;
      end
      else if (wr_fire && !lock_r)
      begin
         if (PADDR == `WDSL_OFS_ENABLE)
            enable_r <= PWDATA[0];
         else if (PADDR == `WDSL_OFS_CONFIG)
            config_r <= PWDATA & 32'h730F_0101;
      end
   end

   // Lock resets clear, so start unlocked until a key write without the unlock code
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         lock_r <= 1'b0;
      else if (wr_fire && PADDR == `WDSL_OFS_KEY)
         lock_r <= (PWDATA[15:0] != `WDSL_KEY_UNLOCK);
   end

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         ien_r <= '0;
      else if (wr_fire && PADDR == `WDSL_OFS_IEN)
         ien_r <= PWDATA[`WDSL_NUM_SRC-1:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command transfer toward the counter
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         sync_st_r  <= SYNC_IDLE;
         sync_cnt_r <= 2'h0;
         busy_r     <= 1'b0;
         sw_clr_p   <= 1'b0;
      end
      else
      begin
         sw_clr_p <= 1'b0;
         case (sync_st_r)
            SYNC_IDLE:
               if (wr_fire && PADDR == `WDSL_OFS_CMD && PWDATA[0])
               begin
                  sync_st_r  <= SYNC_XFER;
                  sync_cnt_r <= 2'(`WDSL_SYNC_CYC - 1);
                  busy_r     <= 1'b1;
               end
            SYNC_XFER:
               if (sync_cnt_r == 2'h0)
               begin
                  sync_st_r <= SYNC_IDLE;
                  busy_r    <= 1'b0;
                  sw_clr_p  <= 1'b1;
               end
               else
                  sync_cnt_r <= sync_cnt_r - 2'h1;
            default:
               sync_st_r <= SYNC_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event inputs and clear selection
   wdsl_sync2 #(.WIDTH(2)) u_evt_sync (
      .clk     (CORE_CLK),
      .rst     (RST),
      .d_async ({EVT1_IN, EVT0_IN}),
      .q_sync  (evt_s)
   );

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         evt_d_r <= 2'h0;
      else
         evt_d_r <= evt_s;
   end

   assign evt_rise = evt_s & ~evt_d_r;
   assign clr = config_r[`WDSL_CFG_CLR_SEL] ? evt_rise[0] : sw_clr_p;

   wdsl_counter #(.PERIOD_SHIFT(PERIOD_SHIFT)) u_cnt (
      .clk     (CORE_CLK),
      .rst     (RST),
      .run     (enable_r),
      .clr     (clr),
      .period_sel (config_r[`WDSL_CFG_PER_HI:`WDSL_CFG_PER_LO]),
      .warnsel    (config_r[`WDSL_CFG_WARN_HI:`WDSL_CFG_WARN_LO]),
      .winsel     (config_r[`WDSL_CFG_WINDOW_HI:`WDSL_CFG_WINDOW_LO]),
      .expiry_p   (expiry_p),
      .warn_p  (warn_p),
      .early   (early)
   );

   // An event seen since the last restart, checked at expiry
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         seen_r <= 2'h0;
      else if (clr || expiry_p)
         seen_r <= evt_rise;
      else
         seen_r <= seen_r | evt_rise;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky flags, write one to clear; a set wins over the clear
   assign ev_set = {expiry_p && !seen_r[1], expiry_p && !seen_r[0],
                    clr && early, warn_p, expiry_p};

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         flags_r <= '0;
      else if (wr_fire && PADDR == `WDSL_OFS_FLAGS)
         flags_r <= (flags_r & ~PWDATA[`WDSL_NUM_SRC-1:0]) | ev_set;
      else
         flags_r <= flags_r | ev_set;
   end

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         IRQ      <= 1'b0;
         WDOG_RST <= 1'b0;
         LOCKED   <= 1'b0;
      end
      else
      begin
         IRQ      <= |(flags_r & ien_r);
         WDOG_RST <= expiry_p && !config_r[`WDSL_CFG_RSTSUP];
         LOCKED   <= lock_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   // Counter clear paths
   a_cmd_sw_clear: assert property (
      (wr_fire && PADDR == `WDSL_OFS_CMD && PWDATA[0] && !busy_r
       && !config_r[`WDSL_CFG_CLR_SEL]) ##1 !config_r[`WDSL_CFG_CLR_SEL][*4]
      |-> clr ##1 u_cnt.cnt_r == 19'h00000)
      else $error("command clear did not reach counter");

   a_evt_clear_mode: assert property (
      config_r[`WDSL_CFG_CLR_SEL] && evt_rise[0] |-> clr ##1 u_cnt.cnt_r == 19'h00000)
      else $error("event edge did not clear counter");

   a_sw_only_mode: assert property (
      !config_r[`WDSL_CFG_CLR_SEL] && clr |-> $past(busy_r) && !busy_r)
      else $error("clear without software command");

   a_sync_busy_hold: assert property (
      wr_fire && PADDR == `WDSL_OFS_CMD && PWDATA[0] && !busy_r
      |=> busy_r[*3] ##1 !busy_r)
      else $error("sync busy timing wrong");

   // Register side
   a_bus_one_wait: assert property (
      acc && !PREADY |=> PREADY)
      else $error("bus answer not after one wait state");

   a_status_lock: assert property (
      acc && !PREADY && !PWRITE && PADDR == `WDSL_OFS_STATUS
      |=> PRDATA[`WDSL_STATUS_LOCK] == lock_r && PRDATA[30:0] == 31'h0)
      else $error("status lock bit wrong");

   a_locked_pin: assert property (
      ##1 LOCKED == $past(lock_r))
      else $error("lock output wrong");

   a_ien_write: assert property (
      wr_fire && PADDR == `WDSL_OFS_IEN |=> ien_r == $past(PWDATA[4:0]))
      else $error("interrupt enable write lost");

   a_ien_readback: assert property (
      acc && !PREADY && !PWRITE && PADDR == `WDSL_OFS_IEN
      |=> PRDATA == {27'h000_0000, $past(ien_r)})
      else $error("interrupt enable readback wrong");

   a_key_lock: assert property (
      wr_fire && PADDR == `WDSL_OFS_KEY
      |=> lock_r == ($past(PWDATA[15:0]) != `WDSL_KEY_UNLOCK))
      else $error("key write gave wrong lock state");

   a_key_reads_zero: assert property (
      acc && !PREADY && !PWRITE && PADDR == `WDSL_OFS_KEY
      |=> PRDATA == 32'h0000_0000)
      else $error("key register read not zero");

   a_locked_config: assert property (
      lock_r && wr_fire |=> $stable(config_r) && $stable(enable_r))
      else $error("locked register changed");

   // Outputs
   a_reset_suppress: assert property (
      expiry_p |=> WDOG_RST == !$past(config_r[`WDSL_CFG_RSTSUP]))
      else $error("reset output disagrees with suppress");

   a_reset_only_expiry: assert property (
      WDOG_RST |-> $past(expiry_p))
      else $error("reset output without expiry");

   a_flag_set_wins: assert property (
      ev_set[0] |=> flags_r[0])
      else $error("expiry flag not set");

   a_irq_level: assert property (
      ##1 IRQ == |($past(flags_r) & $past(ien_r)))
      else $error("interrupt level wrong");

   c_evt_clear: cover property (config_r[`WDSL_CFG_CLR_SEL] && clr);
   c_lock_then_unlock: cover property (lock_r ##[1:50] !lock_r);
   c_timeout_irq: cover property (expiry_p ##[1:3] IRQ);
   c_cmd_clear: cover property (sw_clr_p && !config_r[`WDSL_CFG_CLR_SEL]);
   c_reset_pulse: cover property (WDOG_RST);
endmodule

// file: wdsl_evt_src.sv
// Event channel model driving the two routed event inputs
`timescale 1ns/1ns
module wdsl_evt_src (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Control
   input  wire logic       en,
   input  wire logic [9:0] gap,
   // Event levels
   output logic            evt0,
   output logic            evt1
);
   logic [9:0] cnt_r;
   ////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_r <= 10'h000;
      else if (!en || cnt_r >= gap)
         cnt_r <= 10'h000;
      else
         cnt_r <= cnt_r + 10'h001;
   end
   // Wide pulses so the two-flop capture cannot miss an edge
   assign evt0 = en && (cnt_r < 10'h004);
   assign evt1 = en && (cnt_r >= 10'h004) && (cnt_r < 10'h008);
endmodule

// file: tb.sv
// Self-checking bench for the watchdog service and lock control
`timescale 1ns/1ns
`include "wdsl_cfg.svh"
module tb;
   localparam logic [11:0] CFG = `WDSL_OFS_CONFIG;
   localparam logic [11:0] IEN = `WDSL_OFS_IEN;
   localparam logic [11:0] KEY = `WDSL_OFS_KEY;
   localparam logic [11:0] STA = `WDSL_OFS_STATUS;
   localparam logic [11:0] CMD = `WDSL_OFS_CMD;
   localparam logic [11:0] SYN = `WDSL_OFS_SYNC;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ev_en = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, q, d, rv;
   logic        pready, pslverr, err, irq, wrst, locked, evt0, evt1;
   int          n_errors = 0, num_checks = 0, n_rst = 0, base, i, t0, t1;
   ////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   // Counted mid-cycle so a snapshot taken at a rising edge is never one behind
   always @(negedge clk) if (wrst === 1'b1) n_rst <= n_rst + 1;
   wdsl_top #(.PERIOD_SHIFT(10)) dut_u (.CORE_CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(q),
      .PREADY(pready), .PSLVERR(pslverr), .EVT0_IN(evt0), .EVT1_IN(evt1), .IRQ(irq),
      .WDOG_RST(wrst), .LOCKED(locked));
   wdsl_evt_src evt_u (.clk(clk), .rst(rst), .en(ev_en), .gap(10'h064), .evt0(evt0),
      .evt1(evt1));
   ////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // Implemented fields: clear select, suppress, period, warning, window
   function automatic logic [31:0] exp_cfg(input logic [31:0] v);
      return v & 32'h730F_0101;
   endfunction
   task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      int n;
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= v;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_errors++;
      d = q;
      err = pslverr;
      psel <= 1'b0; pen <= 1'b0;
   endtask
   task wait_rst(output int c);
      c = 0;
      do
      begin
         @(posedge clk);
         c++;
      end
      while (wrst !== 1'b1 && c < 2000);
   endtask
   // Command writes at a fixed cadence, well before each expiry
   task serve(input logic [31:0] v);
      for (i = 0; i < 10; i++)
      begin
         apb(1, CMD, v);
         repeat (100) @(posedge clk);
      end
   endtask
   task complete_run;
      if (n_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (30000) @(posedge clk);
      n_errors++;
      complete_run;
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(72));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      apb(0, CFG, 0); chk("config", `WDSL_CONFIG_RESET, d);
      apb(0, STA, 0); chk("status", 32'h0, d);
      apb(0, KEY, 0); chk("key read", 32'h0, d);
      apb(0, SYN, 0); chk("sync", 32'h0, d);
      apb(0, 12'h0FC, 0); chk("slverr", 32'h1, {31'h0, err});
      for (t0 = 0; t0 < 6; t0++)
      begin
         rv = $urandom;
         apb(1, IEN, rv);
         apb(0, IEN, 0); chk("ien", rv & 32'h1F, d);
      end
      for (t0 = 0; t0 < 4; t0++)
      begin
         apb(1, CFG, 32'h000F0000);
         rv = $urandom;
         if (rv[15:0] == `WDSL_KEY_UNLOCK) rv[0] = ~rv[0];
         apb(1, KEY, rv);
         apb(0, STA, 0); chk("locked", 32'h80000000, d);
         chk("lock pin", 32'h1, {31'h0, locked});
         apb(1, CFG, $urandom);
         apb(0, CFG, 0); chk("locked cfg", 32'h000F0000, d);
         apb(1, KEY, {$urandom} & 32'hFFFF0000 | `WDSL_KEY_UNLOCK);
         apb(0, STA, 0); chk("unlocked", 32'h0, d);
         rv = $urandom;
         apb(1, CFG, rv);
         apb(0, CFG, 0); chk("cfg", exp_cfg(rv), d);
      end
      apb(1, CFG, 32'h000F0000);
      apb(1, `WDSL_OFS_ENABLE, 1);
      wait_rst(t0);
      wait_rst(t1); chk("period", 32'd256, t1);
      base = n_rst; serve(32'h1); chk("served", 32'h0, n_rst - base);
      base = n_rst; serve({$urandom} & 32'hFFFFFFFE);
      chk("unserved", 32'h1, {31'h0, n_rst > base});
      apb(1, CMD, 1);
      apb(0, SYN, 0); chk("busy", 32'h1, d);
      repeat (5) @(posedge clk);
      apb(0, SYN, 0); chk("idle", 32'h0, d);
      apb(1, CFG, 32'h000F0001);
      ev_en <= 1'b1;
      base = n_rst; repeat (1200) @(posedge clk);
      chk("event served", 32'h0, n_rst - base);
      ev_en <= 1'b0;
      base = n_rst; serve(32'h1); chk("cmd ignored", 32'h1, {31'h0, n_rst > base});
      apb(1, CFG, 32'h000F0000);
      ev_en <= 1'b1;
      base = n_rst; repeat (800) @(posedge clk);
      chk("event ignored", 32'h1, {31'h0, n_rst > base});
      ev_en <= 1'b0;
      apb(1, CFG, 32'h000F0100);
      repeat (2) @(posedge clk);
      base = n_rst; repeat (600) @(posedge clk);
      chk("suppressed", 32'h0, n_rst - base);
      apb(0, `WDSL_OFS_FLAGS, 0); chk("expiry flag", 32'h1, d & 32'h1);
      apb(1, IEN, 32'h1); repeat (3) @(posedge clk);
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1, IEN, 32'h2); repeat (3) @(posedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1, `WDSL_OFS_ENABLE, 0);
      apb(1, `WDSL_OFS_FLAGS, 32'h1F);
      apb(1, IEN, 32'h1F); repeat (3) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1, CFG, 32'h000F0000);
      apb(1, KEY, 32'h0);
      apb(1, `WDSL_OFS_ENABLE, 1);
      base = n_rst; repeat (600) @(posedge clk);
      chk("locked enable", 32'h0, n_rst - base);
      complete_run;
   end
endmodule
